//--- rtl/vspwm_map.svh
// Register offsets, field positions, reset values and fixed figures of the scaled PWM block
`ifndef VSPWM_MAP_SVH
`define VSPWM_MAP_SVH
`define VSPWM_IDX_GEN_CFG      8'h00
`define VSPWM_IDX_CUR_CFG      8'h05
`define VSPWM_IDX_FS_VEL       8'h17
`define VSPWM_IDX_SW_VEL       8'h1d
`define VSPWM_IDX_PERIOD       8'h1f
`define VSPWM_IDX_STATUS       8'h20
`define VSPWM_IDX_MOTION       8'h21
`define VSPWM_BIT_PWM_OUT_EN   21
`define VSPWM_FMT_LSB          0
`define VSPWM_FMT_MSB          3
`define VSPWM_FMT_VPWM_A       4'h8
`define VSPWM_FMT_VPWM_B       4'h9
`define VSPWM_BIT_SCALE_EN     8
`define VSPWM_BIT_HOLD_EN      9
`define VSPWM_AMPL_LSB         16
`define VSPWM_HOLD_LSB         0
`define VSPWM_RST_GEN_CFG      32'h0000_0000
`define VSPWM_RST_CUR_CFG      32'h0000_0000
`define VSPWM_RST_FS_VEL       32'h0000_0000
`define VSPWM_RST_SW_VEL       32'h0000_0000
`define VSPWM_RST_PERIOD       32'h0000_0400
`define VSPWM_SCALE_HALF       17'h10000
`define VSPWM_RESP_OKAY        2'b00
`define VSPWM_RESP_SLVERR      2'b10
`endif

//--- rtl/vspwm_pkg.sv
// Types shared by the scaled PWM block
package vspwm_pkg;
  typedef enum logic [1:0] {
    VSPWM_W_IDLE = 2'b00,
    VSPWM_W_RESP = 2'b01
  } vspwm_wstate_t;
endpackage : vspwm_pkg

//--- rtl/vspwm_top.sv
// Velocity scaled two-phase PWM generator with AXI4-Lite registers
// Notes on behaviour
// - PWM period lasts the programmed number of clock cycles.
// - Output enable bit swaps step/dir outputs for coil A and B PWM.
// - Coil A duty follows sine, coil B duty follows cosine.
// - Scaling grows linearly with ramp velocity when scaling enabled.
// - At zero velocity scale is (start amplitude plus one) over 2^17.
// - Scale rises linearly to one half at full-scale velocity.
// - Duty always lies within one half plus or minus scale.
// - Hold scale replaces PWM scale at standstill when hold and scaling enabled.
// - Voltage PWM mode disables serial driver interface, enables PWM.
// - Phase A on driver clock pin, phase B on driver select pin.
// - Mode-select output low in voltage PWM mode.
// - Driver fault input updates three overcurrent/overtemperature status bits in voltage PWM mode.
// - Driver data output pin held high in voltage PWM mode.
// - Only five driver pins driven; board sets the rest.
// - Clearing enable restores serial interface and stops PWM output.
// - Leaving voltage PWM mode drives mode-select high.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "vspwm_map.svh"
module vspwm_top
  import vspwm_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic [31:0] ACTUAL_VELOCITY_I,
  input  wire logic [8:0]  TABLE_SINE_I,
  input  wire logic [8:0]  TABLE_COSINE_I,
  input  wire logic [7:0]  HOLD_SCALE_I,
  input  wire logic        STEP_I,
  input  wire logic        DIR_I,
  input  wire logic        SER_CLK_I,
  input  wire logic        SER_SEL_I,
  input  wire logic        SER_DATA_I,
  input  wire logic        DRIVER_FAULT_I,
  output logic             COIL_A_PWM_OUT_O,
  output logic             COIL_B_PWM_OUT_O,
  output logic             DRIVER_CLOCK_PIN_O,
  output logic             DRIVER_SELECT_PIN_O,
  output logic             DRIVER_DATA_OUT_PIN_O,
  output logic             DRIVER_MODE_SELECT_OUT_O,
  output logic             SERIAL_ACTIVE_O,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // All block state lives in one packed struct.
  // One combinational process builds the next copy,
  // and one clocked process registers it.
  // Configuration words:
  //   gen_cfg  - output format code and PWM output enable
  //   cur_cfg  - start amplitude, scale enable, hold enable
  //   fs_vel   - velocity at which the scale reaches one half
  //   sw_vel   - serial switch velocity, stored only
  //   period   - clock cycles per PWM period
  // Fault path:
  //   fault_sync - three flop chain on the driver fault pin
  //   fault_stat - three status flags fed from the chain
  // PWM engine:
  //   cnt        - free running period counter
  //   thr_a/b    - duty thresholds latched at wrap
  //   pwm_a/b    - registered PWM levels
  // Register bus:
  //   awhave/whave - write address and data held
  //   awaddr/wdata/wstrb - the held items
  //   wst          - write response state
  //   bresp        - write response code
  //   rvalid/rdata/rresp - read answer
  // Hazard: the fault pin is asynchronous, so only
  // the last two flops of the chain are ever compared.
  // Hazard: a period of zero or one keeps the counter
  // at zero; the outputs then sit at a fixed level.
  typedef struct packed {
    logic [31:0]   gen_cfg;
    logic [31:0]   cur_cfg;
    logic [31:0]   fs_vel;
    logic [31:0]   sw_vel;
    logic [31:0]   period;
    logic [2:0]    fault_stat;
    logic [2:0]    fault_sync;
    logic [31:0]   cnt;
    logic [31:0]   thr_a;
    logic [31:0]   thr_b;
    logic          pwm_a;
    logic          pwm_b;
    logic          awhave;
    logic [7:0]    awaddr;
    logic          whave;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    vspwm_wstate_t wst;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } vspwm_state_t;

  vspwm_state_t st_reg;
  vspwm_state_t st_next;

  logic        pwm_on;
  logic        vpwm_mode;
  logic [31:0] abs_vel;
  logic [16:0] ampl_scale;
  logic [16:0] scale;
  logic [47:0] span;
  logic [16:0] ramp_num;
  logic        fault_stable;

  // Threshold arithmetic:
  //   table samples are signed, full scale is 256
  //   scale is unsigned, in units of 2^-17
  //   duty = 1/2 + scale * sample / 256
  //   threshold = period * duty
  // The product of scale and sample carries 2^-25
  // weight, so the period product is shifted by 25.
  // The shift is arithmetic to keep negative offsets.
  // With scale at most one half and samples within
  // -256..255 an even period keeps the threshold within 0..period.
  // Limitation: integer truncation rounds the offset
  // toward minus infinity, so a tiny positive offset
  // vanishes and a tiny negative one costs one cycle.
  // Duty threshold for one table sample: period*(1/2 + scale*sample)
  function automatic logic [31:0] duty_thr(input logic [31:0] per,
                                           input logic [16:0] scl,
                                           input logic [8:0]  smp);
    logic signed [26:0] prod;
    logic signed [63:0] off;
    logic [31:0]        half;
    prod = $signed({1'b0, scl}) * $signed(smp);
    off  = ($signed({32'h0, per}) * 64'(prod)) >>> 25;
    half = per >> 1;
    duty_thr = 32'($signed({32'h0, half}) + off);
  endfunction : duty_thr

  // Mode decode and absolute velocity
  always_comb begin
    pwm_on    = st_reg.gen_cfg[`VSPWM_BIT_PWM_OUT_EN];
    vpwm_mode = pwm_on &&
                ((st_reg.gen_cfg[`VSPWM_FMT_MSB:`VSPWM_FMT_LSB] == `VSPWM_FMT_VPWM_A) ||
                 (st_reg.gen_cfg[`VSPWM_FMT_MSB:`VSPWM_FMT_LSB] == `VSPWM_FMT_VPWM_B));
    abs_vel   = ACTUAL_VELOCITY_I[31] ? 32'(-ACTUAL_VELOCITY_I) : ACTUAL_VELOCITY_I;
  end

  // Scale selection, in priority order:
  //   scaling off          - one half, full swing
  //   standstill with hold - hold scale shifted up by 8
  //   start amplitude only - at zero velocity
  //   above full scale     - clamped to one half
  //   otherwise            - linear ramp between the two
  // The ramp term is (half - start) * |v| / full scale.
  // A full-scale velocity of zero disables the ramp so
  // the divider never sees a zero divisor.
  // A start amplitude above one half is clamped too,
  // since the ramp term would otherwise wrap.
  // Direction is ignored: the magnitude of velocity
  // feeds the ramp, negative velocity is negated.
  // Velocity dependent scale factor in units of 2^-17
  always_comb begin
    ampl_scale = {1'b0, st_reg.cur_cfg[31:`VSPWM_AMPL_LSB]} + 17'h1;
    span       = 48'(`VSPWM_SCALE_HALF - ampl_scale) * 48'(abs_vel);
    ramp_num   = 17'h0;
    if (st_reg.fs_vel != 32'h0) begin
      ramp_num = 17'(span / 48'(st_reg.fs_vel));
    end
    if (!st_reg.cur_cfg[`VSPWM_BIT_SCALE_EN]) begin
      scale = `VSPWM_SCALE_HALF;
    end else if ((abs_vel == 32'h0) && st_reg.cur_cfg[`VSPWM_BIT_HOLD_EN]) begin
      scale = {1'b0, HOLD_SCALE_I, 8'h0};
    end else if (((abs_vel >= st_reg.fs_vel) && (abs_vel != 32'h0)) ||
                 (ampl_scale > `VSPWM_SCALE_HALF)) begin
      scale = `VSPWM_SCALE_HALF;
    end else begin
      scale = ampl_scale + ramp_num;
    end
  end

  // Fault pin filter:
  //   flop 0 takes the raw pin
  //   flops 1 and 2 must agree before a change counts
  // This rejects one cycle glitches on the fault line.
  // The status flags only move in voltage PWM mode;
  // outside it they keep their last value.
  assign fault_stable = (st_reg.fault_sync[2] == st_reg.fault_sync[1]);

  // Write channel timing:
  //   address and data are taken in either order
  //   the register updates on the edge after both held
  //   the response then stands until bready
  //   no new item is taken while a response waits
  // Read channel timing:
  //   the read answer rises on the edge after arvalid
  //   data and code stand until rready
  // Unmapped indices answer with a slave error,
  // and reads of them return zero.
  // Next state: registers, counter, PWM and bus handshakes
  always_comb begin
    logic [7:0]  widx;
    logic [7:0]  ridx;
    logic [31:0] wmask;
    st_next = st_reg;
    widx    = {2'b00, st_reg.awaddr[7:2]};
    ridx    = {2'b00, S_AXI_ARADDR[7:2]};
    wmask   = {{8{st_reg.wstrb[3]}}, {8{st_reg.wstrb[2]}},
               {8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};
    st_next.fault_sync = {st_reg.fault_sync[1:0], DRIVER_FAULT_I};
    // Fault flags follow the driver fault line in voltage PWM mode
    if (vpwm_mode && fault_stable) begin
      st_next.fault_stat = {3{st_reg.fault_sync[2]}};
    end
    // Free-running period counter, thresholds latched at wrap
    if (!pwm_on || (st_reg.cnt + 32'h1 >= st_reg.period)) begin
      st_next.cnt   = 32'h0;
      st_next.thr_a = duty_thr(st_reg.period, scale, TABLE_SINE_I);
      st_next.thr_b = duty_thr(st_reg.period, scale, TABLE_COSINE_I);
    end else begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end
    st_next.pwm_a = pwm_on && (st_next.cnt < st_next.thr_a);
    st_next.pwm_b = pwm_on && (st_next.cnt < st_next.thr_b);
    // Write address and data taken in either order
    if (S_AXI_AWVALID && !st_reg.awhave && st_reg.wst == VSPWM_W_IDLE) begin
      st_next.awhave = 1'b1;
      st_next.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st_reg.whave && st_reg.wst == VSPWM_W_IDLE) begin
      st_next.whave = 1'b1;
      st_next.wdata = S_AXI_WDATA;
      st_next.wstrb = S_AXI_WSTRB;
    end
    case (st_reg.wst)
      VSPWM_W_IDLE: begin
        if (st_reg.awhave && st_reg.whave) begin
          st_next.awhave = 1'b0;
          st_next.whave  = 1'b0;
          st_next.wst    = VSPWM_W_RESP;
          st_next.bresp  = `VSPWM_RESP_OKAY;
          case (widx)
            `VSPWM_IDX_GEN_CFG:
              st_next.gen_cfg = (st_reg.gen_cfg & ~wmask) | (st_reg.wdata & wmask);
            `VSPWM_IDX_CUR_CFG:
              st_next.cur_cfg = (st_reg.cur_cfg & ~wmask) | (st_reg.wdata & wmask);
            `VSPWM_IDX_FS_VEL:
              st_next.fs_vel = (st_reg.fs_vel & ~wmask) | (st_reg.wdata & wmask);
            `VSPWM_IDX_SW_VEL:
              st_next.sw_vel = (st_reg.sw_vel & ~wmask) | (st_reg.wdata & wmask);
            `VSPWM_IDX_PERIOD:
              st_next.period = (st_reg.period & ~wmask) | (st_reg.wdata & wmask);
            default:
              st_next.bresp = `VSPWM_RESP_SLVERR;
          endcase
        end
      end
      VSPWM_W_RESP: begin
        if (S_AXI_BREADY) begin
          st_next.wst = VSPWM_W_IDLE;
        end
      end
      default: st_next.wst = VSPWM_W_IDLE;
    endcase
    // Read channel, one outstanding read
    if (st_reg.rvalid) begin
      if (S_AXI_RREADY) begin
        st_next.rvalid = 1'b0;
      end
    end else if (S_AXI_ARVALID) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `VSPWM_RESP_OKAY;
      case (ridx)
        `VSPWM_IDX_GEN_CFG: st_next.rdata = st_reg.gen_cfg;
        `VSPWM_IDX_CUR_CFG: st_next.rdata = st_reg.cur_cfg;
        `VSPWM_IDX_FS_VEL:  st_next.rdata = st_reg.fs_vel;
        `VSPWM_IDX_SW_VEL:  st_next.rdata = st_reg.sw_vel;
        `VSPWM_IDX_PERIOD:  st_next.rdata = st_reg.period;
        `VSPWM_IDX_STATUS:
          st_next.rdata = {28'h0, vpwm_mode, st_reg.fault_stat};
        `VSPWM_IDX_MOTION:
          st_next.rdata = {15'h0, scale};
        default: begin
          st_next.rdata = 32'h0;
          st_next.rresp = `VSPWM_RESP_SLVERR;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_reg         <= '0;
      st_reg.gen_cfg <= `VSPWM_RST_GEN_CFG;
      st_reg.cur_cfg <= `VSPWM_RST_CUR_CFG;
      st_reg.fs_vel  <= `VSPWM_RST_FS_VEL;
      st_reg.sw_vel  <= `VSPWM_RST_SW_VEL;
      st_reg.period  <= `VSPWM_RST_PERIOD;
      st_reg.wst     <= VSPWM_W_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pin routing summary:
  //   PWM off       - coils carry step and direction
  //   PWM on        - coils carry the two PWM phases
  //   voltage mode  - driver clock pin carries phase A
  //                   driver select pin carries phase B
  //                   driver data pin held high
  //                   mode select driven low
  //   other modes   - serial driver signals pass through
  // Only these five driver pins are touched here; the
  // remaining driver inputs belong to the board.
  // Hazard: the routing is combinational from register
  // decode, so a mode change takes effect on the same edge
  // the write lands, in the middle of a PWM period.
  // Pin multiplexing between step/dir, serial driver and PWM
  always_comb begin
    COIL_A_PWM_OUT_O    = pwm_on ? st_reg.pwm_a : STEP_I;
    COIL_B_PWM_OUT_O    = pwm_on ? st_reg.pwm_b : DIR_I;
    DRIVER_CLOCK_PIN_O  = vpwm_mode ? st_reg.pwm_a : SER_CLK_I;
    DRIVER_SELECT_PIN_O = vpwm_mode ? st_reg.pwm_b : SER_SEL_I;
    DRIVER_DATA_OUT_PIN_O    = vpwm_mode ? 1'b1 : SER_DATA_I;
    DRIVER_MODE_SELECT_OUT_O = !vpwm_mode;
    SERIAL_ACTIVE_O          = !vpwm_mode;
  end

  // Handshake outputs are combinational from state;
  // data and response codes come from flip-flops.
  // Bus handshake outputs
  assign S_AXI_AWREADY = !st_reg.awhave && (st_reg.wst == VSPWM_W_IDLE);
  assign S_AXI_WREADY  = !st_reg.whave && (st_reg.wst == VSPWM_W_IDLE);
  assign S_AXI_BVALID  = (st_reg.wst == VSPWM_W_RESP);
  assign S_AXI_BRESP   = st_reg.bresp;
  assign S_AXI_ARREADY = !st_reg.rvalid;
  assign S_AXI_RVALID  = st_reg.rvalid;
  assign S_AXI_RDATA   = st_reg.rdata;
  assign S_AXI_RRESP   = st_reg.rresp;

endmodule : vspwm_top

//--- verification/vspwm_assertions.sv
// Checker of driver pin routing and register bus handshakes
`timescale 1ns/1ns
module vspwm_chk
  import vspwm_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        RST_B_I,
  input wire logic        SER_CLK_I,
  input wire logic        SER_SEL_I,
  input wire logic        COIL_A_PWM_OUT_O,
  input wire logic        COIL_B_PWM_OUT_O,
  input wire logic        DRIVER_CLOCK_PIN_O,
  input wire logic        DRIVER_SELECT_PIN_O,
  input wire logic        DRIVER_DATA_OUT_PIN_O,
  input wire logic        DRIVER_MODE_SELECT_OUT_O,
  input wire logic        SERIAL_ACTIVE_O,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Voltage PWM mode pin levels
  chk_mode_b_high: assert property (!DRIVER_MODE_SELECT_OUT_O |-> DRIVER_DATA_OUT_PIN_O)
    else $error("data pin not high in voltage mode");
  chk_serial_off: assert property (!DRIVER_MODE_SELECT_OUT_O |-> !SERIAL_ACTIVE_O)
    else $error("serial interface active in voltage mode");
  chk_phase_a_pin: assert property (!DRIVER_MODE_SELECT_OUT_O |->
    DRIVER_CLOCK_PIN_O == COIL_A_PWM_OUT_O)
    else $error("clock pin does not carry phase a");
  chk_phase_b_pin: assert property (!DRIVER_MODE_SELECT_OUT_O |->
    DRIVER_SELECT_PIN_O == COIL_B_PWM_OUT_O)
    else $error("select pin does not carry phase b");
  // Serial mode pass-through
  chk_serial_pass: assert property (DRIVER_MODE_SELECT_OUT_O |->
    SERIAL_ACTIVE_O && DRIVER_CLOCK_PIN_O == SER_CLK_I && DRIVER_SELECT_PIN_O == SER_SEL_I)
    else $error("serial pins not restored");
  chk_mode_leave: assert property ($rose(SERIAL_ACTIVE_O) |-> DRIVER_MODE_SELECT_OUT_O)
    else $error("mode select low after leaving voltage mode");
  // Bus answers
  chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  chk_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  chk_write_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped early");
endmodule : vspwm_chk

bind vspwm_top vspwm_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
  .SER_CLK_I(SER_CLK_I), .SER_SEL_I(SER_SEL_I), .COIL_A_PWM_OUT_O(COIL_A_PWM_OUT_O),
  .COIL_B_PWM_OUT_O(COIL_B_PWM_OUT_O), .DRIVER_CLOCK_PIN_O(DRIVER_CLOCK_PIN_O),
  .DRIVER_SELECT_PIN_O(DRIVER_SELECT_PIN_O), .DRIVER_DATA_OUT_PIN_O(DRIVER_DATA_OUT_PIN_O),
  .DRIVER_MODE_SELECT_OUT_O(DRIVER_MODE_SELECT_OUT_O), .SERIAL_ACTIVE_O(SERIAL_ACTIVE_O),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY));

//--- verification/vspwm_drv_model.sv
// Voltage PWM power driver model returning its fault line
`timescale 1ns/1ns
module vspwm_drv_model (
  input  wire logic clk_i,
  input  wire logic phase_a_i,
  input  wire logic phase_b_i,
  input  wire logic mode_sel_i,
  input  wire logic mode_b_i,
  input  wire logic inject_i,
  output logic      fault_o
);
  logic tog_reg = 1'b0;
  // Serial data shifts while in serial mode, so the line is never a steady level
  always_ff @(posedge clk_i) begin
    tog_reg <= ~tog_reg;
  end
  // Fault flag reported only in voltage mode with mode-B held high
  assign fault_o = mode_sel_i ? tog_reg : (mode_b_i & inject_i);
endmodule : vspwm_drv_model

//--- verification/vspwm_top_tb.sv
// Register-level bench of the scaled PWM block
`timescale 1ns/1ns
module vspwm_top_tb;
  import vspwm_pkg::*;
  logic        clk = 0, rst_b = 0, stp = 0, sck = 0, inj = 0, flt, pa;
  logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wrd, bv, arr, rv;
  logic        ca, cb, dck, dsl, ddo, dms, sact;
  logic [31:0] vel = 0, wd = 0, rdat, rdq;
  logic [8:0]  sn = 0, cs = 0;
  logic [7:0]  hold = 0, aw = 0, ar = 0;
  logic [1:0]  rrsp, brsp;
  int          n_errors = 0, cmp_count = 0, i, ha, hb, ra;
  // Clock
  always #10 clk = ~clk;
  vspwm_top dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .ACTUAL_VELOCITY_I(vel),
    .TABLE_SINE_I(sn), .TABLE_COSINE_I(cs), .HOLD_SCALE_I(hold), .STEP_I(stp), .DIR_I(1'b0),
    .SER_CLK_I(sck), .SER_SEL_I(1'b1), .SER_DATA_I(1'b0), .DRIVER_FAULT_I(flt),
    .COIL_A_PWM_OUT_O(ca), .COIL_B_PWM_OUT_O(cb), .DRIVER_CLOCK_PIN_O(dck),
    .DRIVER_SELECT_PIN_O(dsl), .DRIVER_DATA_OUT_PIN_O(ddo), .DRIVER_MODE_SELECT_OUT_O(dms),
    .SERIAL_ACTIVE_O(sact), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(brsp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ar),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdq), .S_AXI_RRESP(rrsp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
  vspwm_drv_model u_drv (.clk_i(clk), .phase_a_i(dck), .phase_b_i(dsl), .mode_sel_i(dms),
    .mode_b_i(ddo), .inject_i(inj), .fault_o(flt));
  // Verdict and end of run
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // One comparison
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Bus write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    logic ta, tw, tb;
    @(posedge clk);
    aw <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    for (k = 0; k < 100; k++) begin
      @(negedge clk);
      ta = awr; tw = wrd; tb = bv;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tb) break;
    end
    bre <= 0;
    if (k == 100) begin n_errors++; tally_and_finish(); end
  endtask : wr
  // Bus read
  task rd(input logic [7:0] a);
    int k;
    logic tr, tv;
    logic [31:0] td;
    @(posedge clk);
    ar <= a; arv <= 1; rre <= 1;
    for (k = 0; k < 100; k++) begin
      @(negedge clk);
      tr = arr; tv = rv; td = rdq;
      @(posedge clk);
      if (tr) arv <= 0;
      if (tv) begin rdat = td; break; end
    end
    rre <= 0;
    if (k == 100) begin n_errors++; tally_and_finish(); end
  endtask : rd
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk("register", rdat, exp);
  endtask : rchk
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    rchk(8'h7c, 32'h0000_0400);
    rd(8'h40);
    chk("unmapped resp", {30'h0, rrsp}, 32'h2);
    chk("unmapped data", rdat, 32'h0);
    $display("test reset map done");
    wr(8'h14, 32'h00ff_0100);
    repeat (4) @(posedge clk);
    rchk(8'h84, 32'h0000_0100);
    wr(8'h5c, 32'd1000);
    vel <= 32'd1000;
    repeat (4) @(posedge clk);
    rchk(8'h84, 32'h0001_0000);
    vel <= -32'sd2000;
    repeat (4) @(posedge clk);
    rchk(8'h84, 32'h0001_0000);
    wr(8'h14, 32'h00ff_0300);
    vel <= 0; hold <= 8'h40;
    repeat (4) @(posedge clk);
    rchk(8'h84, 32'h0000_4000);
    $display("test scaling done");
    wr(8'h14, 32'h0fff_0100);
    wr(8'h7c, 32'd32);
    sn <= 9'h0ff; cs <= 9'h100; stp <= 1; // Table values taken as is, no offset
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("coil a step", ca, 1);
    wr(8'h00, 32'h0020_0000);
    repeat (70) @(posedge clk);
    ha = 0; hb = 0; ra = 0; pa = ca;
    for (i = 0; i < 96; i++) begin
      @(negedge clk);
      ha += ca; hb += cb; ra += (ca & !pa); pa = ca;
    end
    chk("rising edges", ra, 3);
    chk("duty bounds", ha >= 45 && ha <= 51 && hb >= 45 && hb <= 51, 1);
    chk("sine over cosine", ha >= 48 && hb <= 48, 1);
    $display("test pwm done");
    wr(8'h74, 32'h0);
    rchk(8'h74, 32'h0);
    for (i = 8; i < 10; i++) begin
      wr(8'h00, 32'h0020_0000 | i); // Velocity held at zero here
      inj <= 1;
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk("mode select", dms, 0);
      chk("data pin", ddo, 1);
      chk("serial active", sact, 0);
      rchk(8'h80, 32'h0000_000f);
      inj <= 0;
      repeat (10) @(posedge clk);
      rchk(8'h80, 32'h0000_0008);
    end
    sck <= 1;
    wr(8'h00, 32'h0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("mode select", dms, 1);
    chk("serial active", sact, 1);
    chk("clock pin", dck, 1);
    chk("coil a step", ca, 1);
    $display("test driver mode done");
    tally_and_finish();
  end
endmodule : vspwm_top_tb
